// [pkg/dfp_cc_pkg.sv]
/*
 * Constants and types for the source-role CC attach/detach block.
 * Assumes one 50 MHz clock; slower rates come from enable pulses.
 */
package dfp_cc_pkg;
    // pull-up current select codes
    localparam logic [1:0] RP_OFF = 2'h0;
    localparam logic [1:0] RP_DEFAULT = 2'h1;
    localparam logic [1:0] RP_1A5 = 2'h2;
    localparam logic [1:0] RP_3A0 = 2'h3;
    // comparator control codes
    localparam logic [1:0] CMP_STOP = 2'h0;
    localparam logic [1:0] CMP_CC1 = 2'h1;
    localparam logic [1:0] CMP_CC2 = 2'h2;
    localparam logic [1:0] CMP_BOTH = 2'h3;
    // threshold bit positions in the match result
    localparam int THR_ACT_DEF = 0;
    localparam int THR_ACT_1A5 = 1;
    localparam int THR_ACT_3A0 = 3;
    localparam int THR_OPEN_LOW = 5;
    localparam int THR_OPEN_HIGH = 6;
    localparam int THR_W = 8;
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int KEEPALIVE_HZ = 20_000;
    localparam int KA_DIV = CLK_HZ / KEEPALIVE_HZ;
    localparam int DB_ACTIVE_DELAY = 2;
    localparam logic [THR_W-1:0] RESET_MASK = 8'h00;
    // decoded connection states
    typedef enum logic [2:0] {
        CONN_NONE, CONN_SINK, CONN_CABLE, CONN_CABLE_SINK, CONN_DEBUG, CONN_AUDIO
    } conn_t;
    typedef enum logic [1:0] {TERM_OPEN, TERM_SINK, TERM_CABLE} term_t;
endpackage

// [hw/cc_pin_debounce.sv]
/*
 * Per-pin threshold debouncer: holds a changed comparator vector
 * for the programmed number of keep-alive ticks, then records it.
 * Assumes comparator bits synchronous to mclk_in.
 */
`timescale 1ns/1ns
module cc_pin_debounce (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic tick_in,
    input wire logic [7:0] cmp_in,
    input wire logic [7:0] mask_in,
    input wire logic [7:0] debounce_ticks_in,
    output logic [7:0] match_out,
    output logic changed_out,
    output logic first_done_out
);
    logic [7:0] cand_q;
    logic [7:0] cnt_q;
    logic [7:0] masked;

    assign masked = cmp_in & mask_in;

    // ==========================
    // candidate tracking and commit
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cand_q <= 8'h00;
            cnt_q <= 8'h00;
            match_out <= 8'h00;
            changed_out <= 1'b0;
            first_done_out <= 1'b0;
        end else begin
            changed_out <= 1'b0;
            if (!run_in) begin
                cnt_q <= 8'h00;
                first_done_out <= 1'b0;
            end else if (masked != cand_q) begin
                cand_q <= masked;
                cnt_q <= 8'h00;
            end else if (tick_in) begin
                if (cnt_q >= debounce_ticks_in) begin
                    // commit only after the full interval
                    first_done_out <= 1'b1;
                    if (match_out != cand_q || !first_done_out) begin
                        match_out <= cand_q;
                        changed_out <= (match_out != cand_q);
                    end
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule

// [hw/dfp_cc_attach_detach.sv]
/*
 * Source-role CC attach/detach logic: pull-up select, CC sampling and
 * debounce, connection decode, interrupt summary, VBUS discharge and
 * switch control. All control and status are plain ports driven by
 * host-facing register logic outside this block.
 */
// Summary of operation
// - pull-up field 01b default, 10b 1.5 A, 11b 3.0 A per pin
// - both open: nothing attached, watch both, VBUS and VCONN off
// - sink on one pin: watch it for detach, VBUS on
// - cable only: watch open pin for sink, cable pin for detach, all off
// - cable plus sink: watch sink pin, VBUS and VCONN on
// - two sinks debug, two cables audio; watch both, power off
// - sampling a config-select pin steers pull-up away from CC
// - comparator control 00b stops sampling and debouncer
// - sampling with debounce enabled raises debouncer-active soon after
// - debouncer-active reads 0 once idle; host polls before reprogramming
// - match and change recorded only after debounce, masked thresholds
// - match-valid asserts when both pins finished first debounce
// - enabled match-valid or change raises CC summary and host line
// - host line asserts only for enabled summary sources
// - Result_a-valid raises power summary; vSafe0V match selectable
// - detach sampling runs from the 20 kHz keep-alive tick
// - sink detach when pin exceeds open threshold for advertised level
// - open thresholds: 1.60 V default and 1.5 A, 2.60 V for 3.0 A
// - discharge switch closes until VBUS below vSafe0V
// - discharge timeout raises error interrupt and host line
// - clearing power switch enable opens the 5 V switch
// - per-pin VCONN bits drive FETs; host clears on detach
// - host access wakes oscillator; clock gate keeps only keep-alive
// - communication select routes transceiver to the sink pin
`timescale 1ns/1ns
module dfp_cc_attach_detach (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic [1:0] cc1_rp_sel_in,
    input wire logic [1:0] cc2_rp_sel_in,
    input wire logic config_select_a_in,
    input wire logic config_select_b_in,
    input wire logic [1:0] cc_compare_ctl_in,
    input wire logic cc_debounce_en_in,
    input wire logic [7:0] match_debounce_time_in,
    input wire logic [7:0] cc_threshold_match_mask_in,
    input wire logic [7:0] cc1_cmp_in,
    input wire logic [7:0] cc2_cmp_in,
    input wire logic [2:0] cc_irq_enable_reg_in,
    input wire logic power_irq_enable_reg_in,
    input wire logic [2:0] top_irq_enable_in,
    input wire logic result_a_mask_in,
    input wire logic vbus_safe_zero_in,
    input wire logic vbus_summary_src_in,
    input wire logic port_power_switch_en_in,
    input wire logic discharge_en_in,
    input wire logic [15:0] vbus_discharge_timeout_in,
    input wire logic vconn1_en_in,
    input wire logic vconn2_en_in,
    input wire logic host_access_in,
    input wire logic clock_gate_reg_in,
    input wire logic irq_clear_in,
    output logic [1:0] cc1_rp_drive_out,
    output logic [1:0] cc2_rp_drive_out,
    output logic cc_debouncer_active_out,
    output logic [7:0] cc1_match_result_out,
    output logic [7:0] cc2_match_result_out,
    output logic cc_pin1_changed_out,
    output logic cc_pin2_changed_out,
    output logic cc_result_valid_out,
    output logic vbus_result_valid_out,
    output logic vbus_safe_zero_hit_out,
    output logic cc_summary_irq_out,
    output logic power_summary_irq_out,
    output logic discharge_error_out,
    output logic irq_n_out,
    output dfp_cc_pkg::conn_t conn_state_out,
    output logic [1:0] monitor_pins_out,
    output logic vbus_on_out,
    output logic vconn_on_out,
    output logic vbus_switch_out,
    output logic discharge_switch_out,
    output logic vconn1_fet_out,
    output logic vconn2_fet_out,
    output logic comm_to_cc2_out,
    output logic osc_enable_out
);
    import dfp_cc_pkg::*;

    // ==========================
    // keep-alive tick divider
    logic [15:0] ka_cnt_q;
    logic ka_tick;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ka_cnt_q <= 16'h0000;
        end else if (ka_cnt_q == 16'(KA_DIV - 1)) begin
            ka_cnt_q <= 16'h0000;
        end else begin
            ka_cnt_q <= ka_cnt_q + 16'h0001;
        end
    end
    assign ka_tick = (ka_cnt_q == 16'(KA_DIV - 1));

    // ==========================
    // pull-up drive
    logic cfg_sampling;
    assign cfg_sampling = config_select_a_in | config_select_b_in;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cc1_rp_drive_out <= RP_OFF;
            cc2_rp_drive_out <= RP_OFF;
        end else if (cfg_sampling) begin
            // shared source is busy on the config pins
            cc1_rp_drive_out <= RP_OFF;
            cc2_rp_drive_out <= RP_OFF;
        end else begin
            cc1_rp_drive_out <= cc1_rp_sel_in;
            cc2_rp_drive_out <= cc2_rp_sel_in;
        end
    end

    // ==========================
    // debouncer run control
    logic run1, run2, sampling;
    logic [1:0] act_cnt_q;
    assign sampling = (cc_compare_ctl_in != CMP_STOP) && cc_debounce_en_in;
    assign run1 = sampling && cc_compare_ctl_in[0];
    assign run2 = sampling && cc_compare_ctl_in[1];
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            act_cnt_q <= 2'h0;
            cc_debouncer_active_out <= 1'b0;
        end else if (!sampling) begin
            // reads zero once idle so host may reprogram
            act_cnt_q <= 2'h0;
            cc_debouncer_active_out <= 1'b0;
        end else if (act_cnt_q == 2'(DB_ACTIVE_DELAY)) begin
            cc_debouncer_active_out <= 1'b1;
        end else begin
            act_cnt_q <= act_cnt_q + 2'h1;
        end
    end

    logic done1, done2, chg1, chg2;
    cc_pin_debounce u_deb1 (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(run1),
        .tick_in(ka_tick),
        .cmp_in(cc1_cmp_in),
        .mask_in(cc_threshold_match_mask_in),
        .debounce_ticks_in(match_debounce_time_in),
        .match_out(cc1_match_result_out),
        .changed_out(chg1),
        .first_done_out(done1)
    );
    cc_pin_debounce u_deb2 (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(run2),
        .tick_in(ka_tick),
        .cmp_in(cc2_cmp_in),
        .mask_in(cc_threshold_match_mask_in),
        .debounce_ticks_in(match_debounce_time_in),
        .match_out(cc2_match_result_out),
        .changed_out(chg2),
        .first_done_out(done2)
    );

    // ==========================
    // sticky event flags, set wins over clear
    logic valid_evt, done_both_q;
    assign valid_evt = done1 && done2 && !done_both_q;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            done_both_q <= 1'b0;
        end else begin
            done_both_q <= done1 && done2;
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cc_result_valid_out <= 1'b0;
            cc_pin1_changed_out <= 1'b0;
            cc_pin2_changed_out <= 1'b0;
        end else begin
            cc_result_valid_out <= valid_evt | (cc_result_valid_out & ~irq_clear_in);
            cc_pin1_changed_out <= chg1 | (cc_pin1_changed_out & ~irq_clear_in);
            cc_pin2_changed_out <= chg2 | (cc_pin2_changed_out & ~irq_clear_in);
        end
    end

    // ==========================
    // result_a and discharge
    logic vbus_hit;
    logic safe_q;
    assign vbus_hit = result_a_mask_in & vbus_safe_zero_in;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            safe_q <= 1'b0;
            vbus_safe_zero_hit_out <= 1'b0;
            vbus_result_valid_out <= 1'b0;
        end else begin
            safe_q <= vbus_hit;
            vbus_safe_zero_hit_out <= vbus_hit;
            vbus_result_valid_out <= (vbus_hit & ~safe_q)
                | (vbus_result_valid_out & ~irq_clear_in);
        end
    end

    logic [15:0] dis_cnt_q;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            discharge_switch_out <= 1'b0;
            dis_cnt_q <= 16'h0000;
            discharge_error_out <= 1'b0;
        end else begin
            if (discharge_en_in && !vbus_safe_zero_in
                    && dis_cnt_q < vbus_discharge_timeout_in) begin
                discharge_switch_out <= 1'b1;
                if (ka_tick) begin
                    dis_cnt_q <= dis_cnt_q + 16'h0001;
                end
            end else begin
                // opens on vSafe0V, disable, or timeout
                discharge_switch_out <= 1'b0;
            end
            if (!discharge_en_in) begin
                dis_cnt_q <= 16'h0000;
            end
            discharge_error_out <= (discharge_en_in && !vbus_safe_zero_in
                && dis_cnt_q >= vbus_discharge_timeout_in)
                | (discharge_error_out & ~irq_clear_in);
        end
    end

    // ==========================
    // summary and host interrupt
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cc_summary_irq_out <= 1'b0;
            power_summary_irq_out <= 1'b0;
            irq_n_out <= 1'b1;
        end else begin
            cc_summary_irq_out <= (cc_result_valid_out & cc_irq_enable_reg_in[0])
                | (cc_pin1_changed_out & cc_irq_enable_reg_in[1])
                | (cc_pin2_changed_out & cc_irq_enable_reg_in[2]);
            power_summary_irq_out <= (vbus_result_valid_out & power_irq_enable_reg_in)
                | discharge_error_out;
            irq_n_out <= ~((cc_summary_irq_out & top_irq_enable_in[0])
                | (vbus_summary_src_in & top_irq_enable_in[1])
                | (power_summary_irq_out & top_irq_enable_in[2]));
        end
    end

    // ==========================
    // connection decode from recorded matches
    function automatic term_t classify(input logic [7:0] m, input logic [1:0] rp);
        logic act, open;
        begin
            act = (rp == RP_DEFAULT) ? m[THR_ACT_DEF] :
                  (rp == RP_1A5) ? m[THR_ACT_1A5] : m[THR_ACT_3A0];
            // open threshold follows the advertised level
            open = (rp == RP_3A0) ? m[THR_OPEN_HIGH] : m[THR_OPEN_LOW];
            if (open) begin
                classify = TERM_OPEN;
            end else if (act) begin
                classify = TERM_SINK;
            end else begin
                classify = TERM_CABLE;
            end
        end
    endfunction

    term_t t1, t2;
    assign t1 = classify(cc1_match_result_out, cc1_rp_sel_in);
    assign t2 = classify(cc2_match_result_out, cc2_rp_sel_in);

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            conn_state_out <= CONN_NONE;
            monitor_pins_out <= 2'h3;
            vbus_on_out <= 1'b0;
            vconn_on_out <= 1'b0;
            comm_to_cc2_out <= 1'b0;
        end else begin
            vbus_on_out <= 1'b0;
            vconn_on_out <= 1'b0;
            monitor_pins_out <= 2'h3;
            if (t1 == TERM_OPEN && t2 == TERM_OPEN) begin
                conn_state_out <= CONN_NONE;
            end else if (t1 == TERM_SINK && t2 == TERM_SINK) begin
                conn_state_out <= CONN_DEBUG;
            end else if (t1 == TERM_CABLE && t2 == TERM_CABLE) begin
                conn_state_out <= CONN_AUDIO;
            end else if (t1 == TERM_SINK || t2 == TERM_SINK) begin
                monitor_pins_out <= (t1 == TERM_SINK) ? 2'h1 : 2'h2;
                comm_to_cc2_out <= (t2 == TERM_SINK);
                vbus_on_out <= 1'b1;
                if (t1 == TERM_CABLE || t2 == TERM_CABLE) begin
                    conn_state_out <= CONN_CABLE_SINK;
                    vconn_on_out <= 1'b1;
                end else begin
                    conn_state_out <= CONN_SINK;
                end
            end else begin
                conn_state_out <= CONN_CABLE;
            end
        end
    end

    // ==========================
    // power switches and oscillator
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            vbus_switch_out <= 1'b0;
            vconn1_fet_out <= 1'b0;
            vconn2_fet_out <= 1'b0;
            osc_enable_out <= 1'b1;
        end else begin
            vbus_switch_out <= port_power_switch_en_in;
            vconn1_fet_out <= vconn1_en_in;
            vconn2_fet_out <= vconn2_en_in;
            // host access always wins over the gate
            osc_enable_out <= host_access_in | ~clock_gate_reg_in;
        end
    end

    // ==========================
    // checks
    a_rp_steer_away: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        cfg_sampling |=> cc1_rp_drive_out == RP_OFF && cc2_rp_drive_out == RP_OFF)
        else $error("pull-up driven while config pin sampled");
    a_rp_follow: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !cfg_sampling |=> cc1_rp_drive_out == $past(cc1_rp_sel_in))
        else $error("pull-up select not applied");
    a_stop_idle: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        cc_compare_ctl_in == CMP_STOP |=> !cc_debouncer_active_out)
        else $error("debouncer active while stopped");
    a_active_soon: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        sampling [*4] |=> cc_debouncer_active_out)
        else $error("debouncer active late");
    a_irq_gated: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (top_irq_enable_in == 3'h0) [*2] |=> irq_n_out)
        else $error("host line without enable");
    a_cc_irq_path: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        (cc_pin1_changed_out && cc_irq_enable_reg_in[1]) |=> cc_summary_irq_out)
        else $error("cc summary missed");
    a_discharge_open: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        vbus_safe_zero_in |=> !discharge_switch_out)
        else $error("discharge closed at vSafe0V");
    a_switch_open: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        !port_power_switch_en_in |=> !vbus_switch_out)
        else $error("vbus switch stays closed");
    a_vconn_off: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
        conn_state_out != CONN_CABLE_SINK |-> !vconn_on_out)
        else $error("vconn on in wrong state");

    c_sink_attach: cover property (@(posedge mclk_in) conn_state_out == CONN_SINK);
    c_cable_sink: cover property (@(posedge mclk_in) conn_state_out == CONN_CABLE_SINK);
    c_discharge_err: cover property (@(posedge mclk_in) discharge_error_out);
    c_irq_low: cover property (@(posedge mclk_in) !irq_n_out);
endmodule

// [dv/cc_far_end.sv]
/*
 * Far end of one CC pin: open, sink pull-down or cable pull-down.
 * Assumes the block's pull-up drive code and synchronous comparator bits.
 */
`timescale 1ns/1ns
module cc_far_end (
    input wire logic [1:0] rp_in,
    input wire dfp_cc_pkg::term_t term_in,
    output logic [7:0] cmp_out
);
    import dfp_cc_pkg::*;
    int act;
    int opn;
    // ==========
    // comparator image
    always_comb begin
        act = (rp_in == RP_3A0) ? THR_ACT_3A0 : (rp_in == RP_1A5) ? THR_ACT_1A5 : THR_ACT_DEF;
        opn = (rp_in == RP_3A0) ? THR_OPEN_HIGH : THR_OPEN_LOW;
        cmp_out = 8'h00;
        // no pull-up current means no voltage; a cable pull-down sits below every threshold
        if (rp_in != RP_OFF && term_in != TERM_CABLE) begin
            cmp_out[act] = 1'h1;
            if (term_in == TERM_OPEN) cmp_out[opn] = 1'h1;
        end
    end
endmodule

// [dv/dfp_cc_attach_detach_tb.sv]
/*
 * Self-checking bench: far-end models on both CC pins, reference of the
 * source detection table. Assumes one 50 MHz clock and the hand-over timing.
 */
`timescale 1ns/1ns
module dfp_cc_attach_detach_tb;
    import dfp_cc_pkg::*;
    // ==========
    // signals
    logic mclk_in = 1'h0, sys_rst_in = 1'h1, config_select_a_in = 1'h0;
    logic config_select_b_in = 1'h0, cc_debounce_en_in = 1'h0, power_irq_enable_reg_in = 1'h0;
    logic result_a_mask_in = 1'h0, vbus_safe_zero_in = 1'h0, vbus_summary_src_in = 1'h0;
    logic port_power_switch_en_in = 1'h0, discharge_en_in = 1'h0, vconn1_en_in = 1'h0;
    logic vconn2_en_in = 1'h0, host_access_in = 1'h0, clock_gate_reg_in = 1'h0;
    logic irq_clear_in = 1'h0;
    logic [1:0] cc1_rp_sel_in = 2'h0, cc2_rp_sel_in = 2'h0, cc_compare_ctl_in = 2'h0;
    logic [2:0] cc_irq_enable_reg_in = 3'h7, top_irq_enable_in = 3'h7;
    logic [7:0] match_debounce_time_in = 8'h00, cc_threshold_match_mask_in = 8'h6B;
    logic [15:0] vbus_discharge_timeout_in = 16'h0002;
    logic [7:0] cc1_cmp_in, cc2_cmp_in, cc1_match_result_out, cc2_match_result_out, p1, p2;
    logic [1:0] cc1_rp_drive_out, cc2_rp_drive_out, monitor_pins_out, r, em;
    logic cc_debouncer_active_out, cc_pin1_changed_out, cc_pin2_changed_out;
    logic cc_result_valid_out, vbus_result_valid_out, vbus_safe_zero_hit_out;
    logic cc_summary_irq_out, power_summary_irq_out, discharge_error_out, irq_n_out;
    logic vbus_on_out, vconn_on_out, vbus_switch_out, discharge_switch_out;
    logic vconn1_fet_out, vconn2_fet_out, comm_to_cc2_out, osc_enable_out;
    conn_t conn_state_out, ec;
    term_t t1 = TERM_OPEN, t2 = TERM_OPEN;
    term_t ta[9] = '{TERM_SINK, TERM_OPEN, TERM_CABLE, TERM_OPEN, TERM_CABLE, TERM_SINK,
        TERM_SINK, TERM_CABLE, TERM_OPEN};
    term_t tb[9] = '{TERM_OPEN, TERM_SINK, TERM_OPEN, TERM_CABLE, TERM_SINK, TERM_CABLE,
        TERM_SINK, TERM_CABLE, TERM_OPEN};
    int n_mismatch = 0, checked = 0;

    dfp_cc_attach_detach dut (.*);
    cc_far_end far1 (.rp_in(cc1_rp_drive_out), .term_in(t1), .cmp_out(cc1_cmp_in));
    cc_far_end far2 (.rp_in(cc2_rp_drive_out), .term_in(t2), .cmp_out(cc2_cmp_in));

    // ==========
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic clr;
        irq_clear_in <= 1'h1;
        step(1);
        irq_clear_in <= 1'h0;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_conn(input conn_t e);
        checked++;
        if (conn_state_out !== e) begin
            n_mismatch++;
            $display("Error conn_state expected %s seen %s", e.name(), conn_state_out.name());
        end
    endtask
    function automatic conn_t ref_conn(input term_t a, input term_t b);
        if (a == b) return (a == TERM_SINK) ? CONN_DEBUG : (a == TERM_CABLE) ? CONN_AUDIO : CONN_NONE;
        if (a == TERM_SINK || b == TERM_SINK)
            return (a == TERM_CABLE || b == TERM_CABLE) ? CONN_CABLE_SINK : CONN_SINK;
        return CONN_CABLE;
    endfunction
    task automatic final_report;
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ==========
    // stimulus
    initial forever #10 mclk_in = ~mclk_in;
    initial begin
        #2000000;
        n_mismatch++;
        final_report();
    end
    initial begin
        void'($urandom(62));
        step(11);
        #1 chk("irq_n", 8'h01, irq_n_out);
        chk("monitor_pins", 8'h03, monitor_pins_out);
        step(1);
        sys_rst_in <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            step(1);
            r = (i < 4) ? 2'(i) : 2'($urandom % 4);
            cc1_rp_sel_in <= r;
            cc2_rp_sel_in <= ~r;
            config_select_a_in <= (i == 5);
            config_select_b_in <= (i == 6);
            step(2);
            #1 chk("cc1_rp", (i == 5 || i == 6) ? 2'h0 : r, cc1_rp_drive_out);
            chk("cc2_rp", (i == 5 || i == 6) ? 2'h0 : 2'(~r), cc2_rp_drive_out);
        end
        step(1);
        config_select_a_in <= 1'h0;
        config_select_b_in <= 1'h0;
        cc1_rp_sel_in <= RP_3A0;
        cc2_rp_sel_in <= RP_3A0;
        cc_compare_ctl_in <= CMP_BOTH;
        cc_debounce_en_in <= 1'h1;
        step(DB_ACTIVE_DELAY + 2);
        #1 chk("db_active", 8'h01, cc_debouncer_active_out);
        chk("cc_valid", 8'h00, cc_result_valid_out);
        step(3 * KA_DIV);
        #1 chk("cc_valid", 8'h01, cc_result_valid_out);
        chk_conn(CONN_NONE);
        // each entry changes at least one pin, so a change flag always follows
        for (int i = 0; i < 9; i++) begin
            step(1);
            top_irq_enable_in <= (i == 4) ? 3'h6 : 3'h7;
            clr();
            p1 = cc1_cmp_in & cc_threshold_match_mask_in;
            p2 = cc2_cmp_in & cc_threshold_match_mask_in;
            r = 2'(1 + $urandom % 3);
            cc1_rp_sel_in <= r;
            cc2_rp_sel_in <= r;
            t1 <= ta[i];
            t2 <= tb[i];
            ec = ref_conn(ta[i], tb[i]);
            em = (ta[i] == TERM_SINK) ? 2'h1 : 2'h2;
            if (ec != CONN_SINK && ec != CONN_CABLE_SINK) em = 2'h3;
            // flags of the last entry are still up in the clearing time step
            #1;
            for (int k = 0; k < 3 * KA_DIV && (cc_pin1_changed_out | cc_pin2_changed_out) !== 1'h1;
                k++) step(1);
            step(4);
            #1 chk_conn(ec);
            chk("monitor", em, monitor_pins_out);
            chk("vbus_on", ec == CONN_SINK || ec == CONN_CABLE_SINK, vbus_on_out);
            chk("vconn_on", ec == CONN_CABLE_SINK, vconn_on_out);
            chk("cc1_match", cc1_cmp_in & cc_threshold_match_mask_in, cc1_match_result_out);
            chk("cc2_match", cc2_cmp_in & cc_threshold_match_mask_in, cc2_match_result_out);
            chk("cc_summary", 8'h01, cc_summary_irq_out);
            chk("irq_n", (i == 4) ? 8'h01 : 8'h00, irq_n_out);
            if (em != 2'h3) chk("comm_cc2", em == 2'h2, comm_to_cc2_out);
            chk("changed", {(cc2_cmp_in & cc_threshold_match_mask_in) != p2,
                (cc1_cmp_in & cc_threshold_match_mask_in) != p1},
                {cc_pin2_changed_out, cc_pin1_changed_out});
        end
        step(1);
        cc_compare_ctl_in <= CMP_STOP;
        cc_debounce_en_in <= 1'h0;
        step(DB_ACTIVE_DELAY + 2);
        #1 chk("db_active", 8'h00, cc_debouncer_active_out);
        step(1);
        t1 <= TERM_SINK;
        step(3 * KA_DIV);
        #1 chk_conn(CONN_NONE);
        step(1);
        port_power_switch_en_in <= 1'h1;
        vconn1_en_in <= 1'h1;
        clock_gate_reg_in <= 1'h1;
        step(3);
        #1 chk("vbus_sw", 8'h01, vbus_switch_out);
        chk("vconn_fets", 8'h01, {vconn2_fet_out, vconn1_fet_out});
        chk("osc_en", 8'h00, osc_enable_out);
        step(1);
        port_power_switch_en_in <= 1'h0;
        vconn1_en_in <= 1'h0;
        vconn2_en_in <= 1'h1;
        host_access_in <= 1'h1;
        step(3);
        #1 chk("vbus_sw", 8'h00, vbus_switch_out);
        chk("vconn_fets", 8'h02, {vconn2_fet_out, vconn1_fet_out});
        chk("osc_en", 8'h01, osc_enable_out);
        step(1);
        clr();
        top_irq_enable_in <= 3'h4;
        discharge_en_in <= 1'h1;
        step(3);
        #1 chk("dis_sw", 8'h01, discharge_switch_out);
        for (int k = 0; k < 6 * KA_DIV && discharge_error_out !== 1'h1; k++) step(1);
        step(4);
        #1 chk("dis_err", 8'h01, discharge_error_out);
        chk("irq_n", 8'h00, irq_n_out);
        chk("dis_sw", 8'h00, discharge_switch_out);
        step(1);
        discharge_en_in <= 1'h0;
        step(1);
        clr();
        discharge_en_in <= 1'h1;
        step(100);
        vbus_safe_zero_in <= 1'h1;
        step(3);
        #1 chk("dis_sw", 8'h00, discharge_switch_out);
        chk("dis_err", 8'h00, discharge_error_out);
        step(1);
        discharge_en_in <= 1'h0;
        result_a_mask_in <= 1'h1;
        power_irq_enable_reg_in <= 1'h1;
        for (int k = 0; k < 4 * KA_DIV && vbus_result_valid_out !== 1'h1; k++) step(1);
        step(4);
        #1 chk("vbus_valid", 8'h01, vbus_result_valid_out);
        chk("safe0_hit", 8'h01, vbus_safe_zero_hit_out);
        chk("pwr_summary", 8'h01, power_summary_irq_out);
        chk("irq_n", 8'h00, irq_n_out);
        step(1);
        top_irq_enable_in <= 3'h2;
        vbus_summary_src_in <= 1'h1;
        step(3);
        #1 chk("irq_n", 8'h00, irq_n_out);
        step(1);
        top_irq_enable_in <= 3'h0;
        step(3);
        #1 chk("irq_n", 8'h01, irq_n_out);
        final_report();
    end
endmodule
